// File: pkg/cidec_defs.svh
// Constants of the control and indirect operation decoder: opcode
// patterns, field positions, reset values. Assumes 14-bit instructions.
`ifndef CIDEC_DEFS_SVH
`define CIDEC_DEFS_SVH

// ********************
// Exact opcodes
// ********************
`define CIDEC_OP_NOP 14'h0000
`define CIDEC_OP_SWRESET 14'h0001
`define CIDEC_OP_RETURN 14'h0008
`define CIDEC_OP_INTEXIT 14'h0009
`define CIDEC_OP_CALLACC 14'h000a
`define CIDEC_OP_JMPACC 14'h000b
`define CIDEC_OP_OPTION 14'h0062
`define CIDEC_OP_SLEEP 14'h0063
`define CIDEC_OP_KICK 14'h0064

// ********************
// Prefix patterns
// ********************
`define CIDEC_PFX_RELJMP 5'h19
`define CIDEC_PFX_ABSOLUTE_JUMP 3'h5
`define CIDEC_PFX_CALL 3'h4
`define CIDEC_PFX_RETLIT 6'h34
`define CIDEC_PFX_PIN_DIRECTION_LOAD 11'h00c
`define CIDEC_PFX_PTRADD 7'h62
`define CIDEC_PFX_INDMOD 10'h001
`define CIDEC_PFX_IDXLD 7'h7e
`define CIDEC_PFX_IDXST 7'h7f
`define CIDEC_PFX_ANDIMM 6'h39
`define CIDEC_PFX_ADDIMM 6'h3e
`define CIDEC_PFX_ANDFILE 6'h05

// ********************
// Field positions
// ********************
`define CIDEC_PTR_BIT 2
`define CIDEC_IDX_PTR_BIT 6
`define CIDEC_STORE_BIT 3
`define CIDEC_DEST_BIT 7
`define CIDEC_MSB_BIT 15

// ********************
// Reset values
// ********************
`define CIDEC_PC_RST 11'h000
`define CIDEC_ACC_RST 8'h00
`define CIDEC_PTR_RST 16'h0000
`define CIDEC_EXPIRED_RST 1'b1
`define CIDEC_PD_RST 1'b1

`endif

// File: pkg/cidec_pkg.sv
// Types shared by the decoder files. Assumes the constants header.
`default_nettype none

package cidec_pkg;

	typedef enum logic [2:0] {
		S_READY,
		S_FLUSH,
		S_RDWAIT,
		S_LOAD,
		S_STALL
	} cidec_state_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} cidec_mem_req_t;

	typedef struct packed {
		logic zero;
		logic carry;
		logic halfCarry;
		logic watchdogExpired;
		logic powerDown;
	} cidec_status_t;

endpackage

`default_nettype wire

// File: src/cidec_ptr_add.sv
// Modulo-16-bit adder for indirect pointer arithmetic.
// Assumes the delta is already sign-extended by the caller.
`default_nettype none

module cidec_ptr_add #(
	parameter int WIDTH = 16
) (
	// Operands
	input wire logic [WIDTH-1:0] base,
	input wire logic [WIDTH-1:0] delta,
	// Result
	output logic [WIDTH-1:0] sum
);

	assign sum = base + delta;

endmodule

`default_nettype wire

// File: src/cidec_core.sv
// Control and indirect operation decoder with its own accumulator,
// flags, indirect pointers, program counter and return stack.
// Assumes one instruction offered at a time and a data memory that
// answers a read one cycle after the request.
//
// Summary of operation
// - Relative and accumulator jumps, two cycles
// - Call, absolute jump, call through accumulator
// - Interrupt exit, return, literal return
// - Single-cycle watchdog kick and standby entry
// - Prescale load, no-op, software reset
// - Pin-direction load selected by field
// - Signed offset added to pointer, flags kept
// - Pointer arithmetic wraps at sixteen bits
// - Indirect load with pre/post modify, zero
// - Indexed indirect load, zero flag updated
// - Indirect store with modify, no flags
// - Indexed indirect store of accumulator
// - Program-counter change costs a no-op cycle
// - Access address top bit set adds cycle
// - Literal AND into accumulator, zero only
// - Literal add, carry, half-carry, zero
// - AND with file register, zero only
// - Destination bit routes file result
`default_nettype none
`include "cidec_defs.svh"

module cidec_core #(
	parameter int STACK_DEPTH = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Instruction stream
	input wire logic [13:0] instr,
	input wire logic instrValid,
	output logic instrReady_ff,
	output logic [10:0] pc_ff,
	// Data memory
	output cidec_pkg::cidec_mem_req_t mem_ff,
	input wire logic [7:0] memRdData,
	// Core state
	output logic [7:0] accum_ff,
	output cidec_pkg::cidec_status_t stat_ff,
	// Side effects, one-cycle pulses and the held direction select
	output logic wdtClear_ff,
	output logic sleepReq_ff,
	output logic swReset_ff,
	output logic optionLoad_ff,
	output logic trisLoad_ff,
	output logic [2:0] trisSel_ff,
	output logic gieSet_ff
);

	// ********************
	// Decode
	// ********************
	cidec_pkg::cidec_state_t state_ff, nxtState;
	logic take;
	logic isRelJump, isJumpAcc, isCall, isCallAcc, isAbs;
	logic isIntExit, isReturn, isRetLit, isKick, isSleep;
	logic isOption, isSwReset, isTris, isPtrAdd, isIndMod;
	logic isIdxLd, isIdxSt, isAndImm, isAddImm, isAndFile;
	logic isIndirect, isStore, pcChange;

	assign take = instrValid & instrReady_ff;
	assign isRelJump = instr[13:9] == `CIDEC_PFX_RELJMP;
	assign isJumpAcc = instr == `CIDEC_OP_JMPACC;
	assign isCall = instr[13:11] == `CIDEC_PFX_CALL;
	assign isCallAcc = instr == `CIDEC_OP_CALLACC;
	assign isAbs = instr[13:11] == `CIDEC_PFX_ABSOLUTE_JUMP;
	assign isIntExit = instr == `CIDEC_OP_INTEXIT;
	assign isReturn = instr == `CIDEC_OP_RETURN;
	assign isRetLit = instr[13:8] == `CIDEC_PFX_RETLIT;
	assign isKick = instr == `CIDEC_OP_KICK;
	assign isSleep = instr == `CIDEC_OP_SLEEP;
	assign isOption = instr == `CIDEC_OP_OPTION;
	assign isSwReset = instr == `CIDEC_OP_SWRESET;
	// Exact inherent codes share the direction pattern and win over it
	assign isTris = (instr[13:3] == `CIDEC_PFX_PIN_DIRECTION_LOAD) & ~isKick &
		~isSleep & ~isOption;
	assign isPtrAdd = instr[13:7] == `CIDEC_PFX_PTRADD;
	assign isIndMod = instr[13:4] == `CIDEC_PFX_INDMOD;
	assign isIdxLd = instr[13:7] == `CIDEC_PFX_IDXLD;
	assign isIdxSt = instr[13:7] == `CIDEC_PFX_IDXST;
	assign isAndImm = instr[13:8] == `CIDEC_PFX_ANDIMM;
	assign isAddImm = instr[13:8] == `CIDEC_PFX_ADDIMM;
	assign isAndFile = instr[13:8] == `CIDEC_PFX_ANDFILE;
	assign isIndirect = isIndMod | isIdxLd | isIdxSt;
	assign isStore = (isIndMod & instr[`CIDEC_STORE_BIT]) | isIdxSt;
	assign pcChange = isRelJump | isJumpAcc | isCall | isCallAcc |
		isAbs | isIntExit | isReturn | isRetLit;

	// ********************
	// Targets and arithmetic
	// ********************
	logic [10:0] pcInc, relTarget, accTarget, absTarget, stackTop;
	logic [7:0] litVal, andImmRes, andFileRes;
	logic [8:0] addSum;
	logic [4:0] addLow;
	logic [2:0] trisField;

	assign pcInc = pc_ff + 11'h001;
	assign relTarget = pcInc + {{2{instr[8]}}, instr[8:0]};
	assign accTarget = pcInc + {3'h0, accum_ff};
	assign absTarget = instr[10:0];
	assign litVal = instr[7:0];
	assign trisField = instr[2:0];
	assign andImmRes = accum_ff & litVal;
	assign addSum = {1'b0, accum_ff} + {1'b0, litVal};
	assign addLow = {1'b0, accum_ff[3:0]} + {1'b0, litVal[3:0]};
	assign andFileRes = accum_ff & memRdData;

	// ********************
	// Indirect pointers
	// ********************
	logic [15:0] ptr_ff [2];
	logic [15:0] nxtPtr [2];
	logic ptrN;
	logic [15:0] ptrSel, modDelta, idxDelta, modSum, idxSum, accAddr;
	logic accSlow;

	assign ptrN = (isPtrAdd | isIdxLd | isIdxSt) ?
		instr[`CIDEC_IDX_PTR_BIT] : instr[`CIDEC_PTR_BIT];
	assign ptrSel = ptr_ff[ptrN];
	// Mode bit 0 picks decrement, bit 1 picks post-modify
	assign modDelta = instr[0] ? 16'hffff : 16'h0001;
	assign idxDelta = {{10{instr[5]}}, instr[5:0]};
	assign accAddr = (isIdxLd | isIdxSt) ? idxSum :
		(instr[1] ? ptrSel : modSum);
	assign accSlow = accAddr[`CIDEC_MSB_BIT];

	cidec_ptr_add #(
		.WIDTH(16)
	) u_mod_add (
		.base(ptrSel),
		.delta(modDelta),
		.sum(modSum)
	);

	cidec_ptr_add #(
		.WIDTH(16)
	) u_idx_add (
		.base(ptrSel),
		.delta(idxDelta),
		.sum(idxSum)
	);

	// ********************
	// Return stack
	// ********************
	// No overflow trap: the pointer simply wraps past the depth
	localparam int SPW = $clog2(STACK_DEPTH);
	logic [10:0] stack_ff [STACK_DEPTH];
	logic [SPW-1:0] sp_ff;
	logic doPush, doPop;

	assign stackTop = stack_ff[sp_ff - SPW'(1)];

	// ********************
	// Next state
	// ********************
	logic [10:0] nxtPc;
	logic [7:0] nxtAccum, loadVal;
	cidec_pkg::cidec_status_t nxtStat;
	cidec_pkg::cidec_mem_req_t nxtMem;
	logic nxtWdt, nxtSleep, nxtSwRst, nxtOpt, nxtTris, nxtGie;
	logic pendFile_ff, pendDest_ff, pendSlow_ff;
	logic nxtPendFile, nxtPendDest, nxtPendSlow;

	assign loadVal = pendFile_ff ? andFileRes : memRdData;

	always_comb begin
		nxtState = state_ff;
		nxtPc = pc_ff;
		nxtAccum = accum_ff;
		nxtStat = stat_ff;
		nxtMem = mem_ff;
		nxtMem.rd = 1'b0;
		nxtMem.wr = 1'b0;
		nxtPtr = ptr_ff;
		nxtPendFile = pendFile_ff;
		nxtPendDest = pendDest_ff;
		nxtPendSlow = pendSlow_ff;
		{nxtWdt, nxtSleep, nxtSwRst, nxtOpt, nxtTris, nxtGie} = 6'h00;
		doPush = 1'b0;
		doPop = 1'b0;
		case (state_ff)
			cidec_pkg::S_READY: begin
				if (take) begin
					nxtPc = pcInc;
					if (pcChange) begin
						nxtState = cidec_pkg::S_FLUSH;
					end
					if (isRelJump) begin
						nxtPc = relTarget;
					end else if (isJumpAcc) begin
						nxtPc = accTarget;
					end else if (isCall) begin
						nxtPc = absTarget;
						doPush = 1'b1;
					end else if (isCallAcc) begin
						nxtPc = {pc_ff[10:8], accum_ff};
						doPush = 1'b1;
					end else if (isAbs) begin
						nxtPc = absTarget;
					end else if (isIntExit | isReturn | isRetLit) begin
						nxtPc = stackTop;
						doPop = 1'b1;
						nxtGie = isIntExit;
						if (isRetLit) begin
							nxtAccum = litVal;
						end
					end else if (isKick) begin
						nxtWdt = 1'b1;
						nxtStat.watchdogExpired = 1'b1;
						nxtStat.powerDown = 1'b1;
					end else if (isSleep) begin
						nxtWdt = 1'b1;
						nxtSleep = 1'b1;
						nxtStat.watchdogExpired = 1'b1;
						nxtStat.powerDown = 1'b0;
					end else if (isOption) begin
						nxtOpt = 1'b1;
					end else if (isSwReset) begin
						nxtSwRst = 1'b1;
					end else if (isTris) begin
						nxtTris = 1'b1;
					end else if (isPtrAdd) begin
						nxtPtr[ptrN] = idxSum;
					end else if (isIndirect) begin
						nxtMem.addr = accAddr;
						nxtMem.wdata = accum_ff;
						nxtPendFile = 1'b0;
						nxtPendSlow = accSlow;
						if (isIndMod) begin
							nxtPtr[ptrN] = modSum;
						end
						if (isStore) begin
							nxtMem.wr = 1'b1;
							nxtState = accSlow ? cidec_pkg::S_STALL :
								cidec_pkg::S_READY;
						end else begin
							nxtMem.rd = 1'b1;
							nxtState = cidec_pkg::S_RDWAIT;
						end
					end else if (isAndImm) begin
						nxtAccum = andImmRes;
						nxtStat.zero = andImmRes == 8'h00;
					end else if (isAddImm) begin
						nxtAccum = addSum[7:0];
						nxtStat.carry = addSum[8];
						nxtStat.halfCarry = addLow[4];
						nxtStat.zero = addSum[7:0] == 8'h00;
					end else if (isAndFile) begin
						nxtMem.rd = 1'b1;
						nxtMem.addr = {9'h000, instr[6:0]};
						nxtPendFile = 1'b1;
						nxtPendDest = instr[`CIDEC_DEST_BIT];
						nxtPendSlow = 1'b0;
						nxtState = cidec_pkg::S_RDWAIT;
					end
				end
			end
			cidec_pkg::S_RDWAIT: begin
				nxtState = cidec_pkg::S_LOAD;
			end
			cidec_pkg::S_LOAD: begin
				nxtStat.zero = loadVal == 8'h00;
				if (pendFile_ff & pendDest_ff) begin
					nxtMem.wr = 1'b1;
					nxtMem.wdata = loadVal;
				end else begin
					nxtAccum = loadVal;
				end
				nxtState = pendSlow_ff ? cidec_pkg::S_STALL :
					cidec_pkg::S_READY;
			end
			cidec_pkg::S_FLUSH, cidec_pkg::S_STALL: begin
				nxtState = cidec_pkg::S_READY;
			end
			default: begin
				nxtState = cidec_pkg::S_READY;
			end
		endcase
	end

	// ********************
	// Registers
	// ********************
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_ff <= cidec_pkg::S_READY;
			instrReady_ff <= 1'b0;
			pc_ff <= `CIDEC_PC_RST;
			accum_ff <= `CIDEC_ACC_RST;
			stat_ff <= '{zero: 1'b0, carry: 1'b0, halfCarry: 1'b0,
				watchdogExpired: `CIDEC_EXPIRED_RST,
				powerDown: `CIDEC_PD_RST};
			mem_ff <= '0;
			ptr_ff <= '{default: `CIDEC_PTR_RST};
			{pendFile_ff, pendDest_ff, pendSlow_ff} <= 3'h0;
		end else begin
			state_ff <= nxtState;
			instrReady_ff <= nxtState == cidec_pkg::S_READY;
			pc_ff <= nxtPc;
			accum_ff <= nxtAccum;
			stat_ff <= nxtStat;
			mem_ff <= nxtMem;
			ptr_ff <= nxtPtr;
			{pendFile_ff, pendDest_ff, pendSlow_ff} <=
				{nxtPendFile, nxtPendDest, nxtPendSlow};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			{wdtClear_ff, sleepReq_ff, swReset_ff} <= 3'h0;
			{optionLoad_ff, trisLoad_ff, gieSet_ff} <= 3'h0;
			trisSel_ff <= 3'h0;
		end else begin
			{wdtClear_ff, sleepReq_ff, swReset_ff} <=
				{nxtWdt, nxtSleep, nxtSwRst};
			{optionLoad_ff, trisLoad_ff, gieSet_ff} <=
				{nxtOpt, nxtTris, nxtGie};
			trisSel_ff <= nxtTris ? trisField : trisSel_ff;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			sp_ff <= '0;
		end else if (doPush) begin
			stack_ff[sp_ff] <= pcInc;
			sp_ff <= sp_ff + SPW'(1);
		end else if (doPop) begin
			sp_ff <= sp_ff - SPW'(1);
		end
	end

	// ********************
	// Checks
	// ********************
	property p_rel_jump;
		@(posedge ref_clk) disable iff (!nrst)
		take && isRelJump |=> pc_ff == $past(relTarget);
	endproperty
	a_rel_jump: assert property (p_rel_jump)
		else $error("relative jump target wrong");

	property p_abs_jump;
		@(posedge ref_clk) disable iff (!nrst)
		take && isAbs |=> pc_ff == $past(absTarget) && !instrReady_ff;
	endproperty
	a_abs_jump: assert property (p_abs_jump)
		else $error("absolute jump wrong");

	property p_ret_lit;
		@(posedge ref_clk) disable iff (!nrst)
		take && isRetLit |=> accum_ff == $past(litVal);
	endproperty
	a_ret_lit: assert property (p_ret_lit)
		else $error("literal return did not load accumulator");

	property p_kick;
		@(posedge ref_clk) disable iff (!nrst)
		take && isKick |=> wdtClear_ff && stat_ff.watchdogExpired &&
			stat_ff.powerDown && instrReady_ff;
	endproperty
	a_kick: assert property (p_kick)
		else $error("watchdog kick effects wrong");

	property p_pin_direction_load;
		@(posedge ref_clk) disable iff (!nrst)
		take && isTris |=> trisLoad_ff && trisSel_ff == $past(trisField);
	endproperty
	a_pin_direction_load: assert property (p_pin_direction_load)
		else $error("direction load select wrong");

	property p_ptr_add;
		@(posedge ref_clk) disable iff (!nrst)
		take && isPtrAdd |=> $stable(stat_ff) && instrReady_ff;
	endproperty
	a_ptr_add: assert property (p_ptr_add)
		else $error("pointer add touched flags or stalled");

	property p_flush;
		@(posedge ref_clk) disable iff (!nrst)
		take && pcChange |=> !instrReady_ff ##1 instrReady_ff;
	endproperty
	a_flush: assert property (p_flush)
		else $error("branch did not take exactly two cycles");

	property p_slow_store;
		@(posedge ref_clk) disable iff (!nrst)
		take && isStore && accSlow |=> mem_ff.wr && !instrReady_ff
			##1 instrReady_ff;
	endproperty
	a_slow_store: assert property (p_slow_store)
		else $error("slow store timing wrong");

	property p_add_imm;
		@(posedge ref_clk) disable iff (!nrst)
		take && isAddImm |=> accum_ff == $past(addSum[7:0]) &&
			stat_ff.carry == $past(addSum[8]);
	endproperty
	a_add_imm: assert property (p_add_imm)
		else $error("literal add result wrong");

endmodule

`default_nettype wire

// File: dv/control_and_indirect_op_decoder_test.sv
// Self-checking bench for the control and indirect operation decoder.
// Assumes cidec_core, its package and header; the bench plays program
// side and a data memory that answers one cycle after a read.
`default_nettype none
`include "cidec_defs.svh"

module control_and_indirect_op_decoder_test;
	timeunit 1ns;
	timeprecision 100ps;

	// ********************
	// Signals
	// ********************
	logic ref_clk;
	logic nrst;
	logic [13:0] instr;
	logic instrValid;
	logic [7:0] memRdData;
	logic instrReady_ff;
	logic [10:0] pc_ff;
	cidec_pkg::cidec_mem_req_t mem_ff;
	logic [7:0] accum_ff;
	cidec_pkg::cidec_status_t stat_ff;
	logic wdtClear_ff;
	logic sleepReq_ff;
	logic swReset_ff;
	logic optionLoad_ff;
	logic trisLoad_ff;
	logic [2:0] trisSel_ff;
	logic gieSet_ff;
	logic [5:0] pulses;
	logic rdHit;
	logic [15:0] rdAddr;
	logic [10:0] epc;
	int n_errors;
	int n_compared;

	assign pulses = {wdtClear_ff, sleepReq_ff, swReset_ff, optionLoad_ff,
		trisLoad_ff, gieSet_ff};

	cidec_core #(.STACK_DEPTH(16)) dut (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.instr(instr),
		.instrValid(instrValid),
		.instrReady_ff(instrReady_ff),
		.pc_ff(pc_ff),
		.mem_ff(mem_ff),
		.memRdData(memRdData),
		.accum_ff(accum_ff),
		.stat_ff(stat_ff),
		.wdtClear_ff(wdtClear_ff),
		.sleepReq_ff(sleepReq_ff),
		.swReset_ff(swReset_ff),
		.optionLoad_ff(optionLoad_ff),
		.trisLoad_ff(trisLoad_ff),
		.trisSel_ff(trisSel_ff),
		.gieSet_ff(gieSet_ff)
	);

	// ********************
	// Clock and memory
	// ********************
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Data flips outside the answer cycle, so a late sample fails
	always @(posedge ref_clk) begin
		rdHit = mem_ff.rd;
		rdAddr = mem_ff.addr;
		#1;
		memRdData = rdHit ? rdAddr[7:0] ^ 8'h1f : ~memRdData;
	end

	// ********************
	// Helpers
	// ********************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
			begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic complete_run;
		if (n_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// A gap cycle before each request keeps valid from toggling twice
	task automatic send(input logic [13:0] w, input logic hold);
		int k;
		k = 0;
		do begin
			tick(1);
			k++;
		end while (instrReady_ff !== 1'b1 && k < 20);
		chk(32'(instrReady_ff), 32'h1);
		instr = w;
		instrValid = 1'b1;
		tick(1);
		epc = epc + 11'h1;
		if (!hold)
			instrValid = 1'b0;
	endtask

	task automatic br(input logic [13:0] w, input logic [10:0] tgt,
		input logic [5:0] pl);
		send(w, 1'b0);
		chk(32'({instrReady_ff, pulses, pc_ff}), 32'({1'b0, pl, tgt}));
		tick(1);
		chk(32'({instrReady_ff, pulses, pc_ff}), 32'({7'h40, tgt}));
		epc = tgt;
	endtask

	task automatic ld(input logic [13:0] w, input logic [15:0] ad,
		input logic x);
		logic [7:0] d;
		d = ad[7:0] ^ 8'h1f;
		send(w, 1'b0);
		chk(32'({instrReady_ff, mem_ff.rd, ad}), 32'({2'b01, mem_ff.addr}));
		tick(2);
		if (x) begin
			chk(32'(instrReady_ff), 32'h0);
			tick(1);
		end
		chk(32'({instrReady_ff, stat_ff.zero, accum_ff}),
			32'({1'b1, d == 8'h0, d}));
	endtask

	task automatic af(input logic [7:0] a, input logic d,
		input logic [6:0] f);
		logic [7:0] v;
		v = a & ({1'b0, f} ^ 8'h1f);
		send({`CIDEC_PFX_ANDFILE, d, f}, 1'b0);
		chk(32'({mem_ff.rd, mem_ff.addr}), 32'({8'h80, 2'b0, f}));
		tick(2);
		chk(32'({instrReady_ff, mem_ff.wr, stat_ff.zero, accum_ff}),
			32'({1'b1, d, v == 8'h0, d ? a : v}));
		if (d)
			chk(32'(mem_ff.wdata), 32'(v));
	endtask

	// ********************
	// Scenarios
	// ********************
	task automatic t_reset;
		chk(32'({stat_ff, pc_ff, accum_ff}), 32'h180000);
		chk(32'({instrReady_ff, mem_ff.rd, mem_ff.wr, pulses}), 32'h0);
		tick(1);
		chk(32'(instrReady_ff), 32'h1);
	endtask

	task automatic t_lit;
		logic [13:0] op [6];
		logic [10:0] ex [6];
		op = '{{`CIDEC_PFX_ADDIMM, 8'hff}, {`CIDEC_PFX_ADDIMM, 8'h01},
			{`CIDEC_PFX_ANDIMM, 8'hf0}, {`CIDEC_PFX_ADDIMM, 8'h5a},
			{`CIDEC_PFX_ADDIMM, 8'h0b}, {`CIDEC_PFX_ANDIMM, 8'h0f}};
		ex = '{11'h0ff, 11'h700, 11'h700, 11'h05a, 11'h165, 11'h105};
		for (int i = 0; i < 6; i++) begin
			send(op[i], 1'b0);
			chk(32'({stat_ff.zero, stat_ff.carry, stat_ff.halfCarry,
				accum_ff}), 32'(ex[i]));
			chk(32'(pc_ff), 32'(epc));
		end
	endtask

	task automatic t_inh;
		logic [13:0] op [6];
		logic [7:0] ex [6];
		logic [2:0] fs [5];
		op = '{`CIDEC_OP_KICK, `CIDEC_OP_SLEEP, `CIDEC_OP_KICK,
			`CIDEC_OP_OPTION, `CIDEC_OP_SWRESET, `CIDEC_OP_NOP};
		ex = '{8'h83, 8'hc2, 8'h83, 8'h13, 8'h23, 8'h03};
		fs = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};
		for (int i = 0; i < 6; i++) begin
			send(op[i], 1'b0);
			chk(32'({pulses, stat_ff.watchdogExpired, stat_ff.powerDown}),
				32'(ex[i]));
			chk(32'({instrReady_ff, pc_ff}), 32'({1'b1, epc}));
			tick(1);
			chk(32'(pulses), 32'h0);
		end
		for (int i = 0; i < 5; i++) begin
			send({`CIDEC_PFX_PIN_DIRECTION_LOAD, fs[i]}, 1'b0);
			chk(32'({pulses, trisSel_ff}), 32'({6'h02, fs[i]}));
		end
	endtask

	task automatic t_ref;
		send({`CIDEC_PFX_ABSOLUTE_JUMP, 11'h3c0}, 1'b1);
		instr = {`CIDEC_PFX_ADDIMM, 8'h11};
		tick(1);
		chk(32'({pc_ff, accum_ff}), 32'({11'h3c0, 8'h05}));
		tick(1);
		instrValid = 1'b0;
		chk(32'({pc_ff, accum_ff}), 32'({11'h3c1, 8'h16}));
		epc = 11'h3c1;
	endtask

	task automatic t_ctl;
		logic [10:0] r;
		br({`CIDEC_PFX_RELJMP, 9'h100}, epc - 11'h0ff, 6'h0);
		br({`CIDEC_PFX_RELJMP, 9'h0ff}, epc + 11'h100, 6'h0);
		br(`CIDEC_OP_JMPACC, epc + 11'h017, 6'h0);
		r = epc + 11'h1;
		br({`CIDEC_PFX_CALL, 11'h123}, 11'h123, 6'h0);
		br({`CIDEC_PFX_CALL, 11'h456}, 11'h456, 6'h0);
		br(`CIDEC_OP_RETURN, 11'h124, 6'h0);
		br({`CIDEC_PFX_RETLIT, 8'ha5}, r, 6'h0);
		chk(32'(accum_ff), 32'ha5);
		r = epc + 11'h1;
		br(`CIDEC_OP_CALLACC, {epc[10:8], 8'ha5}, 6'h0);
		br(`CIDEC_OP_INTEXIT, r, 6'h01);
	endtask

	task automatic t_ptr;
		cidec_pkg::cidec_status_t s;
		logic [15:0] ad [4];
		s = stat_ff;
		ad = '{16'h0020, 16'h001f, 16'h001f, 16'h0020};
		send({`CIDEC_PFX_PTRADD, 1'b1, 6'h1f}, 1'b0);
		chk(32'({instrReady_ff, stat_ff}), 32'({1'b1, s}));
		for (int i = 0; i < 4; i++) begin
			send({`CIDEC_PFX_INDMOD, 2'b11, 2'(i)}, 1'b0);
			chk(32'({instrReady_ff, mem_ff.wr, stat_ff, mem_ff.addr}),
				32'({2'b11, s, ad[i]}));
			chk(32'(mem_ff.wdata), 32'ha5);
		end
		send({`CIDEC_PFX_IDXST, 1'b1, 6'h20}, 1'b0);
		chk(32'({instrReady_ff, mem_ff.addr}), 32'h0ffff);
		tick(1);
		chk(32'(instrReady_ff), 32'h1);
		send({`CIDEC_PFX_PTRADD, 1'b0, 6'h3f}, 1'b0);
	endtask

	// ********************
	// Main sequence
	// ********************
	initial begin
		n_errors = 0;
		n_compared = 0;
		nrst = 1'b0;
		instr = 14'h0000;
		instrValid = 1'b0;
		memRdData = 8'h00;
		epc = 11'h000;
		tick(5);
		nrst = 1'b1;
		t_reset;
		t_lit;
		t_inh;
		t_ref;
		t_ctl;
		t_ptr;
		ld({`CIDEC_PFX_INDMOD, 4'h6}, 16'h001f, 1'b0);
		ld({`CIDEC_PFX_IDXLD, 1'b1, 6'h01}, 16'h0021, 1'b0);
		ld({`CIDEC_PFX_IDXLD, 1'b0, 6'h00}, 16'hffff, 1'b1);
		af(8'he0, 1'b1, 7'h7f);
		af(8'he0, 1'b0, 7'h1f);
		complete_run;
	end

	// Run needs about 115 cycles; this bounds a hang
	initial begin
		#20000;
		n_errors++;
		complete_run;
	end
endmodule

`default_nettype wire
